// *** hw/ias_pkg.sv ***
// Shared constants and types of the incremental converter sequencer
package ias_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OSC_HZ = 4_000_000;
  // Oscillator periods per over-sampling period at rate code 00
  localparam int unsigned FS_DIV_MAX = 64;
  localparam int unsigned EXTRA_PERIODS = 1;
  localparam int unsigned RES_W = 16;

  //////////////////////////////////////////////////////////////////////////
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_RES_LO = 8'h50;
  localparam logic [7:0] IDX_RES_HI = 8'h51;
  localparam logic [7:0] IDX_CFG0 = 8'h52;
  localparam logic [7:0] IDX_CFG1 = 8'h53;
  localparam logic [7:0] IDX_CFG2 = 8'h54;
  localparam logic [7:0] IDX_CFG5 = 8'h57;

  // conversion_config_zero fields
  localparam int CFG0_START = 7;
  localparam int CFG0_NELC_LSB = 5;
  localparam int CFG0_OSR_LSB = 2;
  localparam int CFG0_CONT = 1;
  // conversion_config_one fields
  localparam int CFG1_CBIAS_LSB = 6;
  localparam int CFG1_ABIAS_LSB = 4;
  localparam int CFG1_EN_LSB = 0;
  // Rate select field of the third config register
  localparam int CFG2_FS_LSB = 6;
  // Status and trigger register fields
  localparam int CFG5_BUSY = 7;
  localparam int CFG5_DEF = 6;

  localparam logic [7:0] CFG0_RST = 8'h28;
  localparam logic [7:0] CFG1_RST = 8'hF0;
  localparam logic [7:0] CFG2_RST = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_INTEG, SEQ_FINAL} ias_seq_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [9:0] address;
    logic [31:0] writedata;
  } ias_av_req_t;

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// *** hw/ias_rate_div.sv ***
// Over-sampling rate divider: one-cycle tick per over-sampling period
`timescale 1ns/100ps
`default_nettype none

module ias_rate_div #(
  parameter int unsigned OSC_DIV = 10
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [1:0] rate_sel_i,
  output logic tick_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } ias_div_state_t;

  ias_div_state_t st_ff;
  ias_div_state_t nxt_st;
  logic [15:0] period;

  if (OSC_DIV * ias_pkg::FS_DIV_MAX > 65535 || OSC_DIV == 0) begin : g_chk
    $error("ias_rate_div: divider does not fit the counter");
  end

  always_comb begin
    period = 16'(OSC_DIV * (ias_pkg::FS_DIV_MAX >> rate_sel_i));
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    // Held at zero while idle so the first tick is a full period away
    if (!run_i) begin
      nxt_st.cnt = 16'h0000;
    end else if (st_ff.cnt == period - 16'h0001) begin
      nxt_st.cnt = 16'h0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule

`default_nettype wire

// *** hw/ias_sequencer.sv ***
// Incremental converter sequencer with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - ratio code selects 8 to 1024 periods
// - count code selects 1,2,4,8 elementary conversions
// - resolution twice log2 ratio plus log2 count
// - duration count times ratio+1, plus one
// - result two's complement, saturated to full scale
// - unused low bits forced to one-then-zeros
// - result split into high and low bytes
// - converter bias code; host limits sample rate
// - amplifier bias code; host limits sample rate
// - stages switched off while idle
// - code scales input by ratio+1 over ratio
// - start or default bit launches a sequence
// - average conversions, alternating offset polarity
// - over-sampling clock from 4 MHz, four rates
module ias_sequencer #(
  parameter int unsigned CLK_HZ = ias_pkg::CLK_HZ,
  parameter int unsigned OSC_HZ = ias_pkg::OSC_HZ
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire ias_pkg::ias_av_req_t av_req_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  input wire logic mod_bit_i,
  output logic [3:0] stage_enable_o,
  output logic [1:0] converter_bias_o,
  output logic [1:0] amplifier_bias_o,
  output logic offset_polarity_o,
  output logic modulator_strobe_o,
  output logic busy_o
);

  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;

  if (OSC_HZ == 0 || CLK_HZ % OSC_HZ != 0) begin : g_chk
    $error("ias_sequencer: clock is not a multiple of the oscillator");
  end

  typedef struct packed {
    logic [2:0] sync;
    logic bit_q;
    logic wait_q;
    logic [31:0] rdata;
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [15:0] result;
    ias_pkg::ias_seq_t seq;
    logic [2:0] oversampling_ratio;
    logic [1:0] nelc;
    logic [2:0] elem;
    logic [10:0] per;
    logic signed [11:0] acc1;
    logic signed [20:0] acc2;
    logic signed [23:0] sum;
    logic pol;
    logic mstrobe;
    logic [3:0] stage_en;
    logic [1:0] cbias;
    logic [1:0] abias;
    logic busy;
  } ias_state_t;

  ias_state_t st_ff;
  ias_state_t nxt_st;
  logic fs_en;

  ////////////////////////////////////////////////////////////////////////////
  // Code decoding

  function automatic logic [10:0] osr_val(input logic [2:0] code);
    return 11'h008 << code;
  endfunction

  function automatic logic [2:0] elem_last(input logic [1:0] code);
    return 3'((4'h1 << code) - 4'h1);
  endfunction

  // Uncapped resolution in bits, 6 to 23
  function automatic logic [4:0] res_raw(input logic [2:0] o,
                                         input logic [1:0] n);
    return 5'(2 * (o + 3)) + 5'(n);
  endfunction

  // Length of the forced low pattern
  function automatic logic [4:0] forced_len(input logic [2:0] o,
                                            input logic [1:0] n);
    logic [4:0] r;
    r = res_raw(o, n);
    if (o == 3'h0 && n == 2'h0) begin
      return 5'h09;
    end
    return (r >= 5'h10) ? 5'h00 : 5'h10 - r;
  endfunction

  // Scale the summed conversions to 16 bits, saturate, force low bits
  function automatic logic [15:0] finish(input logic signed [23:0] s,
                                         input logic [2:0] o,
                                         input logic [1:0] n);
    logic signed [31:0] v;
    logic [4:0] r;
    logic [4:0] len;
    logic [15:0] q;
    logic [15:0] msk;
    v = 32'(s);
    r = res_raw(o, n);
    len = forced_len(o, n);
    if (r <= 5'h10) begin
      v = v <<< (5'h10 - r);
    end else begin
      v = v >>> (r - 5'h10);
    end
    if (v > 32'sh00007FFF) begin
      q = 16'h7FFF;
    end else if (v < -32'sh00008000) begin
      q = 16'h8000;
    end else begin
      q = v[15:0];
    end
    msk = 16'((17'h00001 << len) - 17'h00001);
    if (len != 5'h00) begin
      q = (q & ~msk) | (16'h0001 << (len - 5'h01));
    end
    return q;
  endfunction

  function automatic logic [7:0] rd_mux(input ias_state_t s,
                                        input logic [9:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == ias_pkg::byte_addr(ias_pkg::IDX_RES_LO)) begin
      d = s.result[7:0];
    end else if (a == ias_pkg::byte_addr(ias_pkg::IDX_RES_HI)) begin
      d = s.result[15:8];
    end else if (a == ias_pkg::byte_addr(ias_pkg::IDX_CFG0)) begin
      d = s.cfg0;
    end else if (a == ias_pkg::byte_addr(ias_pkg::IDX_CFG1)) begin
      d = s.cfg1;
    end else if (a == ias_pkg::byte_addr(ias_pkg::IDX_CFG2)) begin
      d = s.cfg2;
    end else if (a == ias_pkg::byte_addr(ias_pkg::IDX_CFG5)) begin
      d[ias_pkg::CFG5_BUSY] = (s.seq != ias_pkg::SEQ_IDLE);
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Over-sampling clock

  ias_rate_div #(
    .OSC_DIV(OSC_DIV)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(st_ff.seq != ias_pkg::SEQ_IDLE),
    .rate_sel_i(st_ff.cfg2[ias_pkg::CFG2_FS_LSB +: 2]),
    .tick_o(fs_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic start_req;
    logic launch;
    logic wr;
    logic [7:0] wd;
    logic signed [11:0] a1;
    logic signed [20:0] a2;
    logic signed [20:0] es;
    start_req = 1'b0;
    launch = 1'b0;
    wr = 1'b0;
    wd = av_req_i.writedata[7:0];
    a1 = 12'sh000;
    a2 = 21'sh000000;
    es = 21'sh000000;
    nxt_st = st_ff;

    // Modulator bit: accepted once stages two and three agree
    nxt_st.sync = {st_ff.sync[1:0], mod_bit_i};
    if (st_ff.sync[2] == st_ff.sync[1]) begin
      nxt_st.bit_q = st_ff.sync[1];
    end

    // Bus: one wait cycle, then the answer
    if ((av_req_i.read || av_req_i.write) && st_ff.wait_q) begin
      nxt_st.wait_q = 1'b0;
      nxt_st.rdata = {24'h000000, rd_mux(st_ff, av_req_i.address)};
    end else begin
      nxt_st.wait_q = 1'b1;
    end
    wr = av_req_i.write && !st_ff.wait_q && av_req_i.byteenable[0];

    if (wr) begin
      if (av_req_i.address == ias_pkg::byte_addr(ias_pkg::IDX_CFG0)) begin
        nxt_st.cfg0 = {wd[7:1], 1'b0};
        start_req = wd[ias_pkg::CFG0_START];
      end else if (av_req_i.address ==
                   ias_pkg::byte_addr(ias_pkg::IDX_CFG1)) begin
        nxt_st.cfg1 = wd;
      end else if (av_req_i.address ==
                   ias_pkg::byte_addr(ias_pkg::IDX_CFG2)) begin
        nxt_st.cfg2 = wd;
      end else if (av_req_i.address ==
                   ias_pkg::byte_addr(ias_pkg::IDX_CFG5)) begin
        if (wd[ias_pkg::CFG5_DEF]) begin
          nxt_st.cfg0 = ias_pkg::CFG0_RST;
          nxt_st.cfg0[ias_pkg::CFG0_START] = 1'b1;
          nxt_st.cfg1 = ias_pkg::CFG1_RST;
          nxt_st.cfg2 = ias_pkg::CFG2_RST;
          start_req = 1'b1;
        end
      end
    end

    unique case (st_ff.seq)
      ias_pkg::SEQ_IDLE: begin
        launch = start_req;
      end
      ias_pkg::SEQ_INTEG: begin
        if (fs_en) begin
          a1 = st_ff.acc1 + (st_ff.bit_q ? 12'sh001 : -12'sh001);
          a2 = st_ff.acc2 + 21'(a1);
          if (st_ff.per == osr_val(st_ff.oversampling_ratio)) begin
            // Odd conversions see the offset reversed
            es = st_ff.pol ? -a2 : a2;
            nxt_st.sum = st_ff.sum + 24'(es);
            nxt_st.acc1 = 12'sh000;
            nxt_st.acc2 = 21'sh000000;
            nxt_st.per = 11'h000;
            nxt_st.pol = ~st_ff.pol;
            nxt_st.elem = st_ff.elem + 3'h1;
            if (st_ff.elem == elem_last(st_ff.nelc)) begin
              nxt_st.seq = ias_pkg::SEQ_FINAL;
            end
          end else begin
            nxt_st.acc1 = a1;
            nxt_st.acc2 = a2;
            nxt_st.per = st_ff.per + 11'h001;
          end
        end
      end
      ias_pkg::SEQ_FINAL: begin
        if (fs_en) begin
          nxt_st.result = finish(st_ff.sum, st_ff.oversampling_ratio, st_ff.nelc);
          // A start written in this very cycle survives the clear
          if (!start_req) begin
            nxt_st.cfg0[ias_pkg::CFG0_START] = 1'b0;
          end
          // A start landing on the last tick must not be left stranded
          if (nxt_st.cfg0[ias_pkg::CFG0_CONT] || start_req) begin
            launch = 1'b1;
          end else begin
            nxt_st.seq = ias_pkg::SEQ_IDLE;
          end
        end
      end
    endcase

    // Ratio and count are latched so a mid-sequence write cannot skew them; the rate select in cfg2 is read live
    if (launch) begin
      nxt_st.seq = ias_pkg::SEQ_INTEG;
      nxt_st.oversampling_ratio = nxt_st.cfg0[ias_pkg::CFG0_OSR_LSB +: 3];
      nxt_st.nelc = nxt_st.cfg0[ias_pkg::CFG0_NELC_LSB +: 2];
      nxt_st.elem = 3'h0;
      nxt_st.per = 11'h000;
      nxt_st.acc1 = 12'sh000;
      nxt_st.acc2 = 21'sh000000;
      nxt_st.sum = 24'sh000000;
      nxt_st.pol = 1'b0;
    end

    // Analog controls; stages are dark whenever no sequence runs
    nxt_st.mstrobe = fs_en && (st_ff.seq != ias_pkg::SEQ_IDLE);
    nxt_st.busy = (nxt_st.seq != ias_pkg::SEQ_IDLE);
    if (nxt_st.seq != ias_pkg::SEQ_IDLE) begin
      nxt_st.stage_en = nxt_st.cfg1[ias_pkg::CFG1_EN_LSB +: 4];
    end else begin
      nxt_st.stage_en = 4'h0;
    end
    nxt_st.cbias = nxt_st.cfg1[ias_pkg::CFG1_CBIAS_LSB +: 2];
    nxt_st.abias = nxt_st.cfg1[ias_pkg::CFG1_ABIAS_LSB +: 2];
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.wait_q <= 1'b1;
      st_ff.cfg0 <= ias_pkg::CFG0_RST;
      st_ff.cfg1 <= ias_pkg::CFG1_RST;
      st_ff.cfg2 <= ias_pkg::CFG2_RST;
      st_ff.cbias <= ias_pkg::CFG1_RST[ias_pkg::CFG1_CBIAS_LSB +: 2];
      st_ff.abias <= ias_pkg::CFG1_RST[ias_pkg::CFG1_ABIAS_LSB +: 2];
      st_ff.seq <= ias_pkg::SEQ_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign av_readdata_o = st_ff.rdata;
  assign av_waitrequest_o = st_ff.wait_q;
  assign stage_enable_o = st_ff.stage_en;
  assign converter_bias_o = st_ff.cbias;
  assign amplifier_bias_o = st_ff.abias;
  assign offset_polarity_o = st_ff.pol;
  assign modulator_strobe_o = st_ff.mstrobe;
  assign busy_o = st_ff.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [13:0] len_ff;
  logic [13:0] exp_len;
  logic fin_tick;
  assign fin_tick = fs_en && st_ff.seq == ias_pkg::SEQ_FINAL;
  assign exp_len = 14'((15'h1 << st_ff.nelc) * (osr_val(st_ff.oversampling_ratio) + 1)
                       + ias_pkg::EXTRA_PERIODS);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || st_ff.seq == ias_pkg::SEQ_IDLE || fin_tick) begin
      len_ff <= 14'h0000;
    end else if (fs_en) begin
      len_ff <= len_ff + 14'h0001;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_start_write;
    av_req_i.write && !av_waitrequest_o && av_req_i.byteenable[0] &&
    av_req_i.address == ias_pkg::byte_addr(ias_pkg::IDX_CFG0) &&
    av_req_i.writedata[ias_pkg::CFG0_START];
  endsequence

  sequence s_elem_end;
    st_ff.seq == ias_pkg::SEQ_INTEG && fs_en &&
    st_ff.per == osr_val(st_ff.oversampling_ratio);
  endsequence

  property p_start;
    s_start_write and (st_ff.seq == ias_pkg::SEQ_IDLE)
      |=> busy_o ##1 stage_enable_o == st_ff.cfg1[3:0];
  endproperty
  a_start: assert property (p_start)
    else $error("start write did not launch a sequence");

  property p_len;
    fin_tick |-> len_ff + 14'h0001 == exp_len;
  endproperty
  a_len: assert property (p_len)
    else $error("conversion length differs from expected");

  property p_per;
    st_ff.seq == ias_pkg::SEQ_INTEG |-> st_ff.per <= osr_val(st_ff.oversampling_ratio);
  endproperty
  a_per: assert property (p_per)
    else $error("period count ran past the ratio");

  property p_elem;
    s_elem_end and (st_ff.elem == elem_last(st_ff.nelc))
      |=> st_ff.seq == ias_pkg::SEQ_FINAL;
  endproperty
  a_elem: assert property (p_elem)
    else $error("final step not entered after last conversion");

  property p_pol;
    s_elem_end |=> offset_polarity_o != $past(offset_polarity_o);
  endproperty
  a_pol: assert property (p_pol)
    else $error("offset polarity did not alternate");

  property p_idle_off;
    !busy_o ##1 !busy_o |-> stage_enable_o == 4'h0;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("stages powered while idle");

  property p_forced;
    fin_tick |=> forced_len(st_ff.oversampling_ratio, st_ff.nelc) == 5'h00 ||
      ((st_ff.result >> (forced_len(st_ff.oversampling_ratio, st_ff.nelc) - 5'h01))
       & 16'h0001) == 16'h0001;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced low bits missing in result");

  property p_cont;
    fin_tick && nxt_st.cfg0[ias_pkg::CFG0_CONT]
      |=> st_ff.seq == ias_pkg::SEQ_INTEG && st_ff.per == 11'h000;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous mode did not restart");

  property p_read_hi;
    av_req_i.read && av_waitrequest_o &&
    av_req_i.address == ias_pkg::byte_addr(ias_pkg::IDX_RES_HI)
      |=> !av_waitrequest_o &&
          av_readdata_o == {24'h000000, $past(st_ff.result[15:8])};
  endproperty
  a_read_hi: assert property (p_read_hi)
    else $error("high result byte read wrong");

endmodule

`default_nettype wire

// *** verif/ias_mod_model.sv ***
// Modulator bit source for the converter sequencer
`timescale 1ns/100ps
`default_nettype none

module ias_mod_model (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [1:0] mode_i,
  input wire logic strobe_i,
  output logic mod_bit_o
);
  // Fixed levels follow the mode at once, so no stale bit reaches the
  // first sample of a saturation run; random bits change per sample
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mod_bit_o <= 1'b0;
    end else if (mode_i == 2'd0) begin
      mod_bit_o <= 1'b0;
    end else if (mode_i == 2'd1) begin
      mod_bit_o <= 1'b1;
    end else if (strobe_i) begin
      mod_bit_o <= 1'($urandom);
    end
  end
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the converter sequencer
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  ias_pkg::ias_av_req_t req = '0;
  logic [31:0] rdata;
  logic wait_req, mod_bit, pol, strobe, busy;
  logic [3:0] stage_en;
  logic [1:0] cbias, abias;
  logic [1:0] mode = 2'd2;
  int mismatches = 0;
  int n_compared = 0;
  int i;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  logic [31:0] m_ex, m_mk;
  int lut[8] = '{9, 9, 8, 7, 8, 7, 6, 5};

  always #12.5 clk_sys = ~clk_sys;

  ias_sequencer dut (
    .clk_sys_i(clk_sys), .reset_i(reset), .av_req_i(req),
    .av_readdata_o(rdata), .av_waitrequest_o(wait_req),
    .mod_bit_i(mod_bit), .stage_enable_o(stage_en),
    .converter_bias_o(cbias), .amplifier_bias_o(abias),
    .offset_polarity_o(pol), .modulator_strobe_o(strobe), .busy_o(busy)
  );

  ias_mod_model model (
    .clk_sys_i(clk_sys), .reset_i(reset), .mode_i(mode),
    .strobe_i(strobe), .mod_bit_o(mod_bit)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic fail();
    mismatches++;
    give_verdict();
  endtask

  // Read answers are judged here, against notes left by the driver
  always @(posedge clk_sys) begin
    if (req.read && !wait_req) begin
      if (q_exp.size() == 0) begin
        fail();
      end else begin
        m_ex = q_exp.pop_front();
        m_mk = q_msk.pop_front();
        check(rdata & m_mk, m_ex);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] idx,
      input logic [7:0] d, input logic [31:0] mk, input logic [31:0] ex);
    int k;
    if (!wr) begin
      q_msk.push_back(mk);
      q_exp.push_back(ex);
    end
    @(posedge clk_sys);
    req <= '{read: !wr, write: wr, byteenable: 4'hF,
      address: {idx, 2'b00}, writedata: {24'h000000, d}};
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (!wait_req) break;
    end
    req <= '0;
    if (k == 50) fail();
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 60000; k++) begin
      @(posedge clk_sys);
      if (!busy) break;
    end
    if (k == 60000) fail();
  endtask

  task automatic run(input logic [2:0] o, input logic [1:0] n,
      input logic [1:0] r, input logic c);
    int ticks, cyc, gap, k, fl;
    logic saw1;
    logic [3:0] en;
    logic [1:0] cb, ab;
    logic [31:0] mk, ex;
    en = 4'($urandom);
    // Bias never below what the chosen rate needs
    cb = (r == 2'd3) ? 2'b11 : ((r == 2'd2) ? 2'b01 : 2'b00);
    ab = (r < 2'd2) ? 2'b01 : cb;
    bus(1'b1, ias_pkg::IDX_CFG2, {r, 6'h00}, 32'h0, 32'h0);
    bus(1'b1, ias_pkg::IDX_CFG1, {cb, ab, en}, 32'h0, 32'h0);
    bus(1'b1, ias_pkg::IDX_CFG0, {1'b1, n, o, c, 1'b0}, 32'h0, 32'h0);
    ticks = 0;
    gap = 0;
    cyc = 0;
    saw1 = 1'b0;
    for (k = 0; k < 30000; k++) begin
      @(posedge clk_sys);
      cyc++;
      // The last strobe shows up with busy already low: count it first
      if (strobe) begin
        ticks++;
        // Polarity may flip after the last conversion; look before it
        if (pol && ticks <= (1 << n) * (8 << o)) saw1 = 1'b1;
        if (ticks == 1) check(32'(stage_en), 32'(en));
        if (ticks == 2) gap = cyc;
        cyc = 0;
      end
      if ((ticks > 0 && !busy) || (c && ticks == 25)) break;
    end
    if (k == 30000) fail();
    if (c) begin
      check(32'(busy), 32'h1);
    end else begin
      @(posedge clk_sys);
      check(32'(ticks), (32'd1 << n) * ((32'd8 << o) + 32'd1) + 32'd1);
      check(32'(gap), 32'd10 * (32'd64 >> r));
      check(32'(saw1), 32'(n != 2'd0));
      check(32'(stage_en), 32'h0);
      check({28'h0, cbias, abias}, {28'h0, cb, ab});
      fl = lut[{o[0], n}];
      mk = (32'd1 << fl) - 32'd1;
      ex = 32'd1 << (fl - 1);
      // Results read only once idle, never faster than produced
      bus(1'b0, ias_pkg::IDX_RES_HI, 8'h00, mk[15:8], ex[15:8]);
      bus(1'b0, ias_pkg::IDX_RES_LO, 8'h00, mk[7:0], ex[7:0]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(22173));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    check({28'h0, cbias, abias}, 32'h0000000F);
    bus(1'b0, ias_pkg::IDX_RES_LO, 8'h00, 32'hFF, 32'h00);
    bus(1'b0, ias_pkg::IDX_RES_HI, 8'h00, 32'hFF, 32'h00);
    bus(1'b0, ias_pkg::IDX_CFG0, 8'h00, 32'hFF, ias_pkg::CFG0_RST);
    bus(1'b0, ias_pkg::IDX_CFG1, 8'h00, 32'hFF, ias_pkg::CFG1_RST);
    bus(1'b0, ias_pkg::IDX_CFG2, 8'h00, 32'hFF, ias_pkg::CFG2_RST);
    bus(1'b0, ias_pkg::IDX_CFG5, 8'h00, 32'hFF, 32'h00);
    bus(1'b1, 8'h60, 8'hA5, 32'h0, 32'h0);
    bus(1'b0, 8'h60, 8'h00, 32'hFFFFFFFF, 32'h0);
    for (i = 0; i < 4; i++) run(3'd0, 2'd0, 2'(i), 1'b0);
    // Two or more conversions so amplifier offset cancels
    for (i = 1; i < 4; i++) run(3'd0, 2'(i), 2'd3, 1'b0);
    run(3'd1, 2'd0, 2'd3, 1'b0);
    mode <= 2'd1;
    run(3'd0, 2'd0, 2'd3, 1'b0);
    bus(1'b0, ias_pkg::IDX_RES_HI, 8'h00, 32'hFF, 32'h7F);
    mode <= 2'd0;
    run(3'd0, 2'd0, 2'd3, 1'b0);
    bus(1'b0, ias_pkg::IDX_RES_HI, 8'h00, 32'hFF, 32'h81);
    mode <= 2'd2;
    run(3'd0, 2'd0, 2'd3, 1'b1);
    bus(1'b1, ias_pkg::IDX_CFG0, 8'h00, 32'h0, 32'h0);
    wait_idle();
    bus(1'b1, ias_pkg::IDX_CFG5, 8'h40, 32'h0, 32'h0);
    bus(1'b0, ias_pkg::IDX_CFG5, 8'h00, 32'hC0, 32'h80);
    wait_idle();
    bus(1'b0, ias_pkg::IDX_CFG0, 8'h00, 32'hFF, ias_pkg::CFG0_RST);
    give_verdict();
  end
endmodule

`default_nettype wire
